// file: logic/etsc_pkg.sv
// Shared constants and types of the external test start and stop control.
package etsc_pkg;

  // ****************************************************************
  // Timing.
  // ****************************************************************

  // The clock period in nanoseconds.
  localparam int ETSC_CLK_PERIOD_NS = 4;
  // The least closure time of a start or stop contact, in nanoseconds.
  localparam int ETSC_QUAL_TIME_NS = 1000000;
  // The least closure time in clock cycles, rounded up.
  localparam int ETSC_QUAL_CYCLES =
    (ETSC_QUAL_TIME_NS + ETSC_CLK_PERIOD_NS - 1) / ETSC_CLK_PERIOD_NS;
  // The width of the closure counter; it must hold ETSC_QUAL_CYCLES.
  localparam int ETSC_CNT_W = 18;

  // ****************************************************************
  // Contact inputs, one filter each.
  // ****************************************************************

  localparam int ETSC_NUM_IN = 6;
  localparam int ETSC_IN_PANEL_GO = 0;
  localparam int ETSC_IN_PANEL_HALT = 1;
  localparam int ETSC_IN_TERM_GO = 2;
  localparam int ETSC_IN_TERM_HALT = 3;
  localparam int ETSC_IN_PORT_GO = 4;
  localparam int ETSC_IN_PORT_HALT = 5;

  // ****************************************************************
  // Types.
  // ****************************************************************

  // Which party may start tests.
  typedef enum logic [1:0] {
    ETSC_SRC_FRONT,
    ETSC_SRC_TERMINAL,
    ETSC_SRC_PORT
  } etsc_source_type;

  // The test state.
  typedef enum logic [1:0] {
    ETSC_STOPPED,
    ETSC_READY,
    ETSC_RUNNING
  } etsc_state_type;

  // One qualified start and stop pulse pair of a source.
  typedef struct packed {
    logic go;
    logic halt;
  } etsc_req_type;

  // The five status lines of the rear port, first member on line one.
  typedef struct packed {
    logic ready;
    logic running;
    logic stopped;
    logic loop_open;
    logic refused;
  } etsc_status_type;

  // Reset value of the status lines: stopped only.
  localparam etsc_status_type ETSC_STATUS_RESET = 5'h04;

endpackage

// file: logic/etsc_filter.sv
// Contact input synchroniser and closure qualifier.
`timescale 1ns/1ps
`default_nettype none

module etsc_filter #(
  parameter int QUAL_CYCLES = etsc_pkg::ETSC_QUAL_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic raw_i,
  output logic pulse_o
);
  import etsc_pkg::*;

  // Last count of a qualifying run.
  localparam logic [ETSC_CNT_W-1:0] LAST = ETSC_CNT_W'(QUAL_CYCLES - 1);
  // Saturation value of the checking counter.
  localparam logic [ETSC_CNT_W-1:0] SAT = '1;

  logic meta; // First synchroniser stage, read only by the next stage.
  logic sync; // Contact level in the clock domain.
  logic held; // Qualified contact level.
  logic [ETSC_CNT_W-1:0] run; // Cycles the level has differed from held.
  logic differs;
  logic done;

  assign differs = sync != held;
  assign done = differs && (run == LAST);

  // ****************************************************************
  // Synchroniser and qualifier.
  // ****************************************************************

  // A change must stand for the whole run before it is taken, so a
  // glitch shorter than the run restarts the count and is lost.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      held <= 1'b0;
      run <= '0;
      pulse_o <= 1'b0;
    end else begin
      meta <= raw_i;
      sync <= meta;
      if (!differs) begin
        run <= '0;
      end else if (done) begin
        held <= sync;
        run <= '0;
      end else begin
        run <= run + 1'b1;
      end
      // One pulse on the asserting edge of a qualified closure.
      pulse_o <= done && sync;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************

  // Counts consecutive closed cycles, for the check only.
  logic [ETSC_CNT_W-1:0] hi_run;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hi_run <= '0;
    end else if (!sync) begin
      hi_run <= '0;
    end else if (hi_run != SAT) begin
      hi_run <= hi_run + 1'b1;
    end
  end

  a_glitch_filtered: assert property (
    @(posedge clk_i) disable iff (reset_i)
    pulse_o |-> (int'(hi_run) >= QUAL_CYCLES))
    else $error("closure pulse after too short a contact");

  a_pulse_once: assert property (
    @(posedge clk_i) disable iff (reset_i)
    pulse_o |=> !pulse_o)
    else $error("closure pulse longer than one cycle");

endmodule

`default_nettype wire

// file: logic/etsc_ctrl.sv
// Test start and stop gating for panel, terminal and rear port sources.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Terminal start and stop act like panel.
// - Terminal ignored unless it is the source.
// - Terminal source: only terminal starts tests.
// - Panel stop halts tests under any source.
// - Front source restores panel start and stop.
// - Rear port obeyed only when it is source.
// - Rear stop closure of 1ms gives READY.
// - Rear start closure of 1ms begins test.
// - Rear stop closure stops a running test.
// - Rear status lines show the test state.
// - Interlock on: start needs closed safety loop.
// - Interlock on: opened loop aborts running test.
// - Interlock off: safety loop is ignored.
module etsc_ctrl #(
  parameter int QUAL_CYCLES = etsc_pkg::ETSC_QUAL_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire etsc_pkg::etsc_source_type control_source_i,
  input wire logic interlock_on_i,
  input wire logic panel_go_i,
  input wire logic panel_halt_i,
  input wire logic terminal_go_in_i,
  input wire logic terminal_halt_in_i,
  input wire logic port_go_i,
  input wire logic port_halt_i,
  input wire logic safety_loop_b_i,
  output logic safety_loop_a_o,
  output etsc_pkg::etsc_state_type test_state_o,
  output etsc_pkg::etsc_status_type status_o
);
  import etsc_pkg::*;

  // ****************************************************************
  // Source selection.
  // ****************************************************************

  // Picks the start and stop pulses of the selected source. An unused
  // source code starts nothing, so a bad setting cannot start a test.
  function automatic etsc_req_type pick_req(
    input etsc_source_type src,
    input etsc_req_type front,
    input etsc_req_type term,
    input etsc_req_type port
  );
    etsc_req_type sel;
    sel = '0;
    case (src)
      ETSC_SRC_FRONT: begin
        sel = front;
      end
      ETSC_SRC_TERMINAL: begin
        sel = term;
      end
      ETSC_SRC_PORT: begin
        sel = port;
      end
      default: begin
        sel = '0;
      end
    endcase
    return sel;
  endfunction

  // ****************************************************************
  // Input qualification.
  // ****************************************************************

  logic [ETSC_NUM_IN-1:0] raw_in; // Contact levels, closed is high.
  logic [ETSC_NUM_IN-1:0] closure; // One-cycle qualified closures.

  assign raw_in[ETSC_IN_PANEL_GO] = panel_go_i;
  assign raw_in[ETSC_IN_PANEL_HALT] = panel_halt_i;
  assign raw_in[ETSC_IN_TERM_GO] = terminal_go_in_i;
  assign raw_in[ETSC_IN_TERM_HALT] = terminal_halt_in_i;
  assign raw_in[ETSC_IN_PORT_GO] = port_go_i;
  assign raw_in[ETSC_IN_PORT_HALT] = port_halt_i;

  // Every contact goes through the same filter, the panel buttons too,
  // so that all sources behave alike at the cost of 1ms of latency.
  for (genvar g = 0; g < ETSC_NUM_IN; g++) begin : g_filt
    etsc_filter #(
      .QUAL_CYCLES(QUAL_CYCLES)
    ) u_filt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .raw_i(raw_in[g]),
      .pulse_o(closure[g])
    );
  end

  // The safety loop is a level; two stages bring it into the domain.
  logic loop_meta; // First stage, read only by loop_sync.
  logic loop_sync; // High while the loop is closed.

  // ****************************************************************
  // Request decoding.
  // ****************************************************************

  etsc_req_type panel_req; // Front panel buttons.
  etsc_req_type term_req; // Remote terminal contacts.
  etsc_req_type port_req; // Rear port contacts.
  etsc_req_type sel_req; // Requests of the selected source.
  logic halt_any; // Any stop that applies now.
  logic loop_ok; // The interlock allows a test.
  logic start_ok; // A start is taken this cycle.
  logic refuse_ev; // A start is refused by the interlock.
  logic abort_ev; // The interlock aborts a running test.

  assign panel_req.go = closure[ETSC_IN_PANEL_GO];
  assign panel_req.halt = closure[ETSC_IN_PANEL_HALT];
  assign term_req.go = closure[ETSC_IN_TERM_GO];
  assign term_req.halt = closure[ETSC_IN_TERM_HALT];
  assign port_req.go = closure[ETSC_IN_PORT_GO];
  assign port_req.halt = closure[ETSC_IN_PORT_HALT];

  // Terminal and port pulses pass only when their source is chosen.
  assign sel_req = pick_req(control_source_i, panel_req, term_req,
                            port_req);

  // The panel stop is always honoured, whatever the source.
  assign halt_any = sel_req.halt | panel_req.halt;

  // With the interlock off the loop level plays no part.
  assign loop_ok = !interlock_on_i || loop_sync;

  // A stop in the same cycle wins over a start.
  assign start_ok = sel_req.go && !halt_any && loop_ok;
  assign refuse_ev = sel_req.go && !halt_any && !loop_ok;
  assign abort_ev = interlock_on_i && !loop_sync;

  // ****************************************************************
  // Test state.
  // ****************************************************************

  etsc_state_type state; // Current test state.
  etsc_state_type next_state;
  etsc_status_type next_status;

  // A stop while running halts the test; a stop while stopped arms
  // READY, which is the only state in which a start is taken.
  always_comb begin
    next_state = state;
    case (state)
      ETSC_STOPPED: begin
        if (halt_any) begin
          next_state = ETSC_READY;
        end
      end
      ETSC_READY: begin
        if (start_ok) begin
          next_state = ETSC_RUNNING;
        end
      end
      ETSC_RUNNING: begin
        if (abort_ev || halt_any) begin
          next_state = ETSC_STOPPED;
        end
      end
      default: begin
        next_state = ETSC_STOPPED;
      end
    endcase
  end

  // Status lines follow the next state so they change with it.
  always_comb begin
    next_status.ready = next_state == ETSC_READY;
    next_status.running = next_state == ETSC_RUNNING;
    next_status.stopped = next_state == ETSC_STOPPED;
    next_status.loop_open = interlock_on_i && !loop_sync;
    // A refusal stands until a start is taken; a stop in READY does not clear it.
    if ((state == ETSC_READY) && refuse_ev) begin
      next_status.refused = 1'b1;
    end else if (next_state != ETSC_READY) begin
      next_status.refused = 1'b0;
    end else begin
      next_status.refused = status_o.refused;
    end
  end

  // All state and outputs; outputs come straight from these flops.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      loop_meta <= 1'b0;
      loop_sync <= 1'b0;
      safety_loop_a_o <= 1'b0;
      state <= ETSC_STOPPED;
      test_state_o <= ETSC_STOPPED;
      status_o <= ETSC_STATUS_RESET;
    end else begin
      loop_meta <= safety_loop_b_i;
      loop_sync <= loop_meta;
      safety_loop_a_o <= 1'b1;
      state <= next_state;
      test_state_o <= next_state;
      status_o <= next_status;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************

  a_terminal_start: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (control_source_i == ETSC_SRC_TERMINAL) && (state == ETSC_READY)
      && term_req.go && !halt_any && loop_ok
      |=> (test_state_o == ETSC_RUNNING) && status_o.running)
    else $error("terminal start did not begin a test");

  a_terminal_ignored: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (control_source_i != ETSC_SRC_TERMINAL) && (state == ETSC_READY)
      && term_req.go && !sel_req.go
      |=> test_state_o == ETSC_READY)
    else $error("terminal start taken while not the source");

  a_panel_masked: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (control_source_i == ETSC_SRC_TERMINAL) && (state == ETSC_READY)
      && panel_req.go && !term_req.go
      |=> test_state_o == ETSC_READY)
    else $error("panel start taken under terminal source");

  a_panel_stop: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state == ETSC_RUNNING) && panel_req.halt
      |=> test_state_o == ETSC_STOPPED)
    else $error("panel stop did not halt the test");

  a_front_restored: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (control_source_i == ETSC_SRC_FRONT) && (state == ETSC_READY)
      && panel_req.go && !panel_req.halt && loop_ok
      |=> test_state_o == ETSC_RUNNING)
    else $error("panel start ignored under front source");

  a_port_ignored: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (control_source_i != ETSC_SRC_PORT) && (state == ETSC_RUNNING)
      && port_req.halt && !panel_req.halt && !sel_req.halt
      && !abort_ev
      |=> test_state_o == ETSC_RUNNING)
    else $error("rear stop taken while not the source");

  a_stop_readies: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (control_source_i == ETSC_SRC_PORT) && (state == ETSC_STOPPED)
      && port_req.halt
      |=> status_o.ready ##1 !status_o.stopped)
    else $error("rear stop did not give READY");

  a_port_start: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (control_source_i == ETSC_SRC_PORT) && (state == ETSC_READY)
      && port_req.go && !halt_any && loop_ok
      |=> (test_state_o == ETSC_RUNNING) && status_o.running)
    else $error("rear start did not begin a test from READY");

  a_port_stop: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (control_source_i == ETSC_SRC_PORT) && (state == ETSC_RUNNING)
      && port_req.halt
      |=> status_o.stopped && !status_o.running)
    else $error("rear stop did not halt the test");

  a_status_lines: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (status_o.running == (test_state_o == ETSC_RUNNING))
      && (status_o.ready == (test_state_o == ETSC_READY))
      && (status_o.stopped == (test_state_o == ETSC_STOPPED)))
    else $error("status lines disagree with the test state");

  a_lock_refuse: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state == ETSC_READY) && interlock_on_i && !loop_sync
      |=> (test_state_o != ETSC_RUNNING))
    else $error("test started with the safety loop open");

  a_lock_abort: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state == ETSC_RUNNING) && interlock_on_i && !loop_sync
      |=> (test_state_o == ETSC_STOPPED) && status_o.loop_open)
    else $error("open safety loop did not abort the test");

  a_lock_off: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state == ETSC_RUNNING) && !interlock_on_i && !halt_any
      |=> (test_state_o == ETSC_RUNNING) && !status_o.loop_open)
    else $error("safety loop acted with the interlock off");

endmodule

`default_nettype wire

// file: test/etsc_fixture.sv
// External start and stop fixture with contacts and an interlock key.
`timescale 1ns/1ps
`default_nettype none

module etsc_fixture #(
  parameter int QC = 4
) (
  input wire logic clk_i,
  input wire logic safety_loop_a_i,
  output var logic [5:0] contact_o,
  output logic safety_loop_b_o
);
  // ****************************************************************
  // Contacts and loop.
  // ****************************************************************

  // High while the interlock key shorts the two loop pins.
  logic key_in = 1'b0;

  // An open loop reads low, so a removed key never echoes the drive.
  assign safety_loop_b_o = key_in & safety_loop_a_i;

  initial begin
    contact_o = 6'h00;
  end

  // Close one contact for len cycles, then hold it open long enough.
  // The release is held past the qualifying time so the next closure
  // of the same contact counts as new.
  task automatic close_contact(input int idx, input int len);
    @(posedge clk_i);
    contact_o[idx] <= 1'b1;
    repeat (len) @(posedge clk_i);
    contact_o[idx] <= 1'b0;
    repeat (QC + 6) @(posedge clk_i);
  endtask

  // Insert or remove the interlock key on a clock edge.
  task automatic set_key(input logic inserted);
    @(posedge clk_i);
    key_in <= inserted;
  endtask
endmodule
`default_nettype wire

// file: test/etsc_tb.sv
// Self-checking testbench of the test start and stop control.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import etsc_pkg::*;
  localparam int QC = 4;
  localparam int LIMIT = 8000;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  etsc_source_type control_source_i = ETSC_SRC_FRONT;
  logic interlock_on_i = 1'b0;
  logic [5:0] contact;
  logic safety_loop_b;
  logic safety_loop_a;
  etsc_state_type test_state_o;
  etsc_status_type status_o;
  // Expected {state, status} notes, oldest first.
  logic [6:0] notes[$];
  logic [6:0] prev;
  logic run_watch = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ****************************************************************
  // Clock, design and fixture.
  // ****************************************************************

  always #2 clk_i = ~clk_i;

  etsc_ctrl #(.QUAL_CYCLES(QC)) DUT (
    .clk_i(clk_i), .reset_i(reset_i),
    .control_source_i(control_source_i),
    .interlock_on_i(interlock_on_i),
    .panel_go_i(contact[ETSC_IN_PANEL_GO]),
    .panel_halt_i(contact[ETSC_IN_PANEL_HALT]),
    .terminal_go_in_i(contact[ETSC_IN_TERM_GO]),
    .terminal_halt_in_i(contact[ETSC_IN_TERM_HALT]),
    .port_go_i(contact[ETSC_IN_PORT_GO]),
    .port_halt_i(contact[ETSC_IN_PORT_HALT]),
    .safety_loop_b_i(safety_loop_b),
    .safety_loop_a_o(safety_loop_a),
    .test_state_o(test_state_o), .status_o(status_o));

  etsc_fixture #(.QC(QC)) fix (
    .clk_i(clk_i), .safety_loop_a_i(safety_loop_a),
    .contact_o(contact), .safety_loop_b_o(safety_loop_b));

  // ****************************************************************
  // Checking.
  // ****************************************************************

  // Print the counts and the verdict, then end the run.
  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    fails++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  // Any output change takes the oldest note; a change with no note
  // pending means an input that should be ignored was obeyed.
  always @(negedge clk_i) begin
    if (run_watch && {test_state_o, status_o} !== prev) begin
      samples_checked++;
      if (notes.size() == 0) begin
        fail("output changed with nothing expected");
      end else if (notes[0] !== {test_state_o, status_o}) begin
        fail("state or status differs from expected");
      end
      if (notes.size() > 0) begin
        void'(notes.pop_front());
      end
    end
    prev <= {test_state_o, status_o};
  end

  // Cut a hang short.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= LIMIT) begin
      fail("timeout");
      print_verdict();
    end
  end

  // ****************************************************************
  // Stimulus helpers.
  // ****************************************************************

  // Note a result if one is due, then close one contact in full.
  task automatic step(input int idx, input logic ch,
                      input etsc_state_type s, input etsc_status_type st);
    if (ch) begin
      notes.push_back({s, st});
    end
    fix.close_contact(idx, QC + $urandom_range(3, 0));
  endtask

  // A closure shorter than the qualifying time must be lost.
  task automatic glitch(input int idx);
    fix.close_contact(idx, $urandom_range(QC - 1, 1));
  endtask

  task automatic source(input logic [1:0] code);
    @(posedge clk_i);
    control_source_i <= etsc_source_type'(code);
    repeat (6) @(posedge clk_i);
  endtask

  // Change the key with the result it should bring, then let it settle.
  task automatic key(input logic ins, input etsc_state_type s,
                     input etsc_status_type st);
    notes.push_back({s, st});
    fix.set_key(ins);
    repeat (10) @(posedge clk_i);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************

  initial begin
    void'($urandom(67216));
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    samples_checked++;
    if (test_state_o !== ETSC_STOPPED || status_o !== 5'h04) begin
      fail("reset state wrong");
    end
    run_watch = 1'b1;
    // Front panel, interlock off with no key fitted.
    glitch(ETSC_IN_PANEL_HALT);
    step(ETSC_IN_PANEL_HALT, 1, ETSC_READY, 5'h10);
    step(ETSC_IN_TERM_GO, 0, ETSC_READY, 5'h10);
    step(ETSC_IN_PANEL_GO, 1, ETSC_RUNNING, 5'h08);
    step(ETSC_IN_PANEL_GO, 0, ETSC_RUNNING, 5'h08);
    step(ETSC_IN_PANEL_HALT, 1, ETSC_STOPPED, 5'h04);
    // Remote terminal selected.
    source(2'h1);
    step(ETSC_IN_PANEL_HALT, 1, ETSC_READY, 5'h10);
    step(ETSC_IN_PANEL_GO, 0, ETSC_READY, 5'h10);
    step(ETSC_IN_PORT_GO, 0, ETSC_READY, 5'h10);
    glitch(ETSC_IN_TERM_GO);
    step(ETSC_IN_TERM_GO, 1, ETSC_RUNNING, 5'h08);
    step(ETSC_IN_TERM_HALT, 1, ETSC_STOPPED, 5'h04);
    glitch(ETSC_IN_TERM_HALT);
    step(ETSC_IN_TERM_HALT, 1, ETSC_READY, 5'h10);
    // Rear port selected.
    source(2'h2);
    step(ETSC_IN_TERM_GO, 0, ETSC_READY, 5'h10);
    step(ETSC_IN_PANEL_GO, 0, ETSC_READY, 5'h10);
    step(ETSC_IN_PORT_GO, 1, ETSC_RUNNING, 5'h08);
    step(ETSC_IN_PANEL_HALT, 1, ETSC_STOPPED, 5'h04);
    glitch(ETSC_IN_PORT_HALT);
    step(ETSC_IN_PORT_HALT, 1, ETSC_READY, 5'h10);
    step(ETSC_IN_PORT_GO, 1, ETSC_RUNNING, 5'h08);
    step(ETSC_IN_PORT_HALT, 1, ETSC_STOPPED, 5'h04);
    // Unassigned source code: nobody starts, panel stop still works.
    source(2'h3);
    step(ETSC_IN_PANEL_HALT, 1, ETSC_READY, 5'h10);
    step(ETSC_IN_PANEL_GO, 0, ETSC_READY, 5'h10);
    // Back to the front panel.
    source(2'h0);
    step(ETSC_IN_PORT_GO, 0, ETSC_READY, 5'h10);
    step(ETSC_IN_PANEL_GO, 1, ETSC_RUNNING, 5'h08);
    step(ETSC_IN_PORT_HALT, 0, ETSC_RUNNING, 5'h08);
    step(ETSC_IN_PANEL_HALT, 1, ETSC_STOPPED, 5'h04);
    step(ETSC_IN_PANEL_HALT, 1, ETSC_READY, 5'h10);
    // Interlock on with the loop open, then closed, then opened.
    notes.push_back({ETSC_READY, 5'h12});
    @(posedge clk_i);
    interlock_on_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    step(ETSC_IN_PANEL_GO, 1, ETSC_READY, 5'h13);
    key(1'b1, ETSC_READY, 5'h11);
    step(ETSC_IN_PANEL_GO, 1, ETSC_RUNNING, 5'h08);
    key(1'b0, ETSC_STOPPED, 5'h06);
    key(1'b1, ETSC_STOPPED, 5'h04);
    repeat (20) @(posedge clk_i);
    samples_checked++;
    if (notes.size() != 0) begin
      fail("expected results never appeared");
    end
    print_verdict();
  end
endmodule
`default_nettype wire
